// [inc/btb_pkg.sv]
package btb_pkg;
	localparam int NUM_CH   = 4;            // channels a, b, c, d
	localparam int Q_DEPTH  = 4;            // trace queue depth
	localparam int CH_D     = 3;            // last channel of any chain
	localparam int NO_CHAIN = 4;            // chain start when independent
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [2:0]  Q_CNT_RST = 3'h0;
	localparam logic [3:0]  FLAGS_RST = 4'h0;
	localparam int SHORT_LOOP = 3;          // loops this short never fetch

	typedef enum logic [1:0] {
		BTB_SEQ_NONE, BTB_SEQ_CD, BTB_SEQ_BCD, BTB_SEQ_ABCD
	} btb_seq_e;
	typedef enum logic [1:0] {BTB_FLOW_BRANCH, BTB_FLOW_REPEAT,
		BTB_FLOW_INTR} btb_flow_e;
	typedef enum logic [1:0] {BTB_DIR_ANY, BTB_DIR_RD, BTB_DIR_WR} btb_dir_e;
	typedef enum logic [1:0] {BTB_SZ_ANY, BTB_SZ_B, BTB_SZ_W, BTB_SZ_L}
		btb_size_e;
	typedef enum logic [1:0] {BTB_XY_MAIN, BTB_XY_X, BTB_XY_Y} btb_xy_e;

	// one bus cycle seen by the comparators
	typedef struct packed {
		logic        valid;
		logic        dma;       // 1: on-chip dma master, 0: cpu
		logic        fetch;     // 1: instruction fetch, 0: data access
		logic        write;
		btb_size_e   size;
		btb_xy_e     xy;
		logic [31:0] addr;      // x/y cycles carry address in [15:0]
		logic [31:0] data;
	} btb_cycle_s;

	// one channel's break condition
	typedef struct packed {
		logic        en_cpu;
		logic        en_dma;
		logic        sel_fetch;
		logic        sel_data;
		btb_dir_e    dir;
		btb_size_e   size;
		logic        pre;       // fetch break before execution
		logic        xy_en;
		logic        y_sel;
		logic        data_en;
		logic        cnt_en;
		logic [15:0] count;
		logic [31:0] addr;
		logic [31:0] amask;     // 1 = bit not compared
		logic [31:0] data;
		logic [31:0] dmask;
	} btb_chan_s;

	// one change of flow reported by the core
	typedef struct packed {
		logic        valid;
		btb_flow_e   kind;
		logic [2:0]  loop_len;  // repeat loop length, 7 = long
		logic        tgt_pend;  // intr before delayed target executed
		logic [31:0] src;       // last fetch address before the flow
		logic [31:0] dst;       // first fetch address at the target
		logic [31:0] tgt;       // delayed branch target, if pending
		logic [7:0]  ptr;
	} btb_flow_s;

	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
		logic [7:0]  ptr;
		logic        ptr_bad;
	} btb_entry_s;
endpackage

// [rtl/btb_top.sv]
`timescale 1ns/10ps
// Summary of operation
// - capture trace only while trace enable set
// - every traced flow change stores source and destination
// - destination is target's first fetch address
// - source is last fetch before flow change
// - pointer gives pre-branch address as source minus 2xpointer
// - pending 4n+2 delayed target stored, pointer invalid
// - pre-branch location depends on flow kind
// - interrupt destination is service routine start
// - loops of three or fewer never traced
// - four-entry queue for source, destination, pointer
// - reads show head; destination read advances queue
// - mask ones exclude address bits from compare
// - pre breaks before execution, post after
// - fetch with write direction never matches
// - c-then-d mode breaks on d after c
// - unmatchable first channel blocks whole chain
// - execution counts gate channel satisfaction
// - unsized read matches all sizes at address
// - data compare on unmasked bits only
// - y-memory channel compares lower address half
// - dma fetch condition never matches
module btb_top (
	// clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_b,
	// trace control and core flow events
	input  wire logic                  i_trace_enable_bit,
	input  wire btb_pkg::btb_flow_s    i_flow,
	// trace register reads, one-cycle strobes
	input  wire logic                  i_rd_trace_destination,
	// trace head
	output logic [31:0]                o_trace_source_reg,
	output logic [31:0]                o_trace_destination_reg,
	output logic [7:0]                 o_trace_pointer_reg,
	output logic                       o_trace_ptr_invalid,
	output logic [2:0]                 o_trace_count,
	// break configuration
	input  wire btb_pkg::btb_seq_e     i_seq_mode,
	input  wire btb_pkg::btb_chan_s    i_chan [btb_pkg::NUM_CH],
	input  wire logic                  i_count_load,
	input  wire logic [3:0]            i_flag_clr,
	// observed bus cycles and retirement
	input  wire btb_pkg::btb_cycle_s   i_cpu_cycle,
	input  wire btb_pkg::btb_cycle_s   i_dma_cycle,
	input  wire logic                  i_insn_done,
	// break outputs
	output logic                       o_break_pre,
	output logic                       o_break_post,
	output logic [3:0]                 o_match_flags
);
	localparam int NC = btb_pkg::NUM_CH;
	localparam int QD = btb_pkg::Q_DEPTH;

	// all state of the block
	typedef struct packed {
		btb_pkg::btb_entry_s [QD-1:0] q;      // q[0] is the head
		logic [2:0]                   cnt;    // occupied entries
		logic [2:0]                   stage;  // next channel of the chain
		logic [NC-1:0]                flags;  // sticky match flags
		logic [NC-1:0][15:0]          ecnt;   // execution counters
		logic                         post_pend;
		logic                         brk_pre;
		logic                         brk_post;
	} btb_state_s;

	btb_state_s        st_reg;     // registered state
	btb_state_s        st_next;    // next state
	logic [NC-1:0]     raw;        // per-channel bus condition match
	logic [NC-1:0]     cnt_ok;     // count condition satisfied
	logic [2:0]        start;      // first channel of the chain

	// per-channel comparators, cpu and dma cycles both checked
	genvar gi;
	generate
		for (gi = 0; gi < NC; gi++) begin : g_ch
			btb_pkg::btb_chan_s c;
			logic               hit_cpu;
			logic               hit_dma;
			assign c = i_chan[gi];

			// full compare of one cycle against this channel
			function automatic logic cyc_hit(btb_pkg::btb_cycle_s y);
				logic [31:0] ca;
				logic [31:0] cm;
				logic [31:0] ya;
				logic [31:0] dm;
				logic        ok;
				ca = c.addr;
				cm = c.amask;
				ya = y.addr;
				ok = y.valid;
				// x/y bus uses one half of the address fields
				if (c.xy_en) begin
					ok = ok && (y.xy == (c.y_sel ? btb_pkg::BTB_XY_Y
						: btb_pkg::BTB_XY_X));
					ca = {16'h0000, c.y_sel ? c.addr[15:0]
						: c.addr[31:16]};
					cm = {16'h0000, c.y_sel ? c.amask[15:0]
						: c.amask[31:16]};
					ya = {16'h0000, y.addr[15:0]};
				end else begin
					ok = ok && (y.xy == btb_pkg::BTB_XY_MAIN);
				end
				// an unsized condition ignores lanes the access covers
				if (c.size == btb_pkg::BTB_SZ_ANY) begin
					if (y.size == btb_pkg::BTB_SZ_L)
						cm[1:0] = 2'h3;
					else if (y.size == btb_pkg::BTB_SZ_W)
						cm[0] = 1'b1;
				end else begin
					ok = ok && (y.size == c.size);
				end
				ok = ok && (((ca ^ ya) & ~cm) == 32'h00000000);
				// cycle type; fetch+write cannot exist
				ok = ok && (y.fetch ? c.sel_fetch : c.sel_data);
				ok = ok && !(c.sel_fetch && y.fetch
					&& c.dir == btb_pkg::BTB_DIR_WR);
				if (c.dir == btb_pkg::BTB_DIR_RD)
					ok = ok && !y.write;
				else if (c.dir == btb_pkg::BTB_DIR_WR)
					ok = ok && y.write;
				// byte and word data sit in the low half only
				dm = c.dmask;
				if (c.size != btb_pkg::BTB_SZ_L)
					dm[31:16] = 16'hFFFF;
				if (c.data_en)
					ok = ok && (((c.data ^ y.data) & ~dm)
						== 32'h00000000);
				return ok;
			endfunction

			assign hit_cpu = c.en_cpu && cyc_hit(i_cpu_cycle);
			// dma never fetches, so a dma fetch condition stays dead
			assign hit_dma = c.en_dma && !i_dma_cycle.fetch
				&& cyc_hit(i_dma_cycle);
			// simultaneous cpu and dma hits count once
			assign raw[gi] = hit_cpu || hit_dma;
			assign cnt_ok[gi] = !c.cnt_en
				|| (st_reg.ecnt[gi] == btb_pkg::CNT_ONE);
		end
	endgenerate

	// chain entry point from the sequence mode
	always_comb begin
		unique case (i_seq_mode)
			btb_pkg::BTB_SEQ_NONE: start = 3'(btb_pkg::NO_CHAIN);
			btb_pkg::BTB_SEQ_CD:   start = 3'h2;
			btb_pkg::BTB_SEQ_BCD:  start = 3'h1;
			btb_pkg::BTB_SEQ_ABCD: start = 3'h0;
		endcase
	end

	// next-state logic for trace queue and break matching
	always_comb begin
		logic              push;
		logic              pop;
		logic [2:0]        stg;
		logic [2:0]        wi;
		logic              brk;
		logic              armed;
		logic              sat;
		btb_pkg::btb_entry_s ne;
		btb_pkg::btb_chan_s  ch;
		logic [2:0]        stg0;   // chain stage as it stood this cycle
		logic [NC-1:0]     fset;   // flags raised by a match this cycle
		logic              pset;   // post break armed by a match this cycle
		push = 1'b0;
		pop = 1'b0;
		stg = 3'h0;
		wi = 3'h0;
		brk = 1'b0;
		armed = 1'b0;
		sat = 1'b0;
		ne = '0;
		ch = '0;
		stg0 = 3'h0;
		fset = '0;
		pset = 1'b0;
		st_next = st_reg;
		st_next.brk_pre = 1'b0;
		st_next.brk_post = 1'b0;

		// trace entry build
		ne.src = i_flow.src;
		ne.dst = i_flow.dst;
		ne.ptr = i_flow.ptr;
		ne.ptr_bad = 1'b0;
		// interrupt before a 4n+2 delayed target: keep the target
		if (i_flow.kind == btb_pkg::BTB_FLOW_INTR && i_flow.tgt_pend
			&& i_flow.tgt[1]) begin
			ne.src = i_flow.tgt;
			ne.ptr_bad = 1'b1;
		end
		// short loops make no fetch, so nothing is known to record
		push = i_flow.valid && i_trace_enable_bit
			&& !(i_flow.kind == btb_pkg::BTB_FLOW_REPEAT
			&& i_flow.loop_len <= 3'(btb_pkg::SHORT_LOOP));
		pop = i_rd_trace_destination && (st_reg.cnt != 3'h0);
		// full queue drops the oldest entry to keep the newest
		if (pop || (push && st_reg.cnt == 3'(QD))) begin
			for (int k = 0; k < QD - 1; k++)
				st_next.q[k] = st_reg.q[k+1];
		end
		if (push) begin
			wi = (pop || st_reg.cnt == 3'(QD)) ? st_reg.cnt - 3'h1
				: st_reg.cnt;
			st_next.q[wi[1:0]] = ne;
		end
		if (push && !pop && st_reg.cnt != 3'(QD))
			st_next.cnt = st_reg.cnt + 3'h1;
		else if (pop && !push)
			st_next.cnt = st_reg.cnt - 3'h1;

		// chain stage clamped to the active chain
		stg = (st_reg.stage < start) ? start : st_reg.stage;
		stg0 = stg;
		for (int i = 0; i < NC; i++) begin
			ch = i_chan[i];
			// chained channels only count once their turn has come; a
			// turn that opens this cycle waits, so c and d together
			// count as c alone
			armed = (3'(i) < start) || (stg0 == 3'(i));
			sat = raw[i] && armed && cnt_ok[i];
			if (ch.cnt_en && raw[i] && armed) begin
				st_next.ecnt[i] = cnt_ok[i] ? ch.count
					: st_reg.ecnt[i] - btb_pkg::CNT_ONE;
			end
			if (sat) begin
				st_next.flags[i] = 1'b1;
				fset[i] = 1'b1;
				if (3'(i) < start) begin
					brk = 1'b1;
				end else if (i == btb_pkg::CH_D) begin
					brk = 1'b1;
					stg = start;
				end else begin
					stg = stg + 3'h1;
				end
				if (brk) begin
					if (ch.pre && ch.sel_fetch)
						st_next.brk_pre = 1'b1;
					else
					begin
						st_next.post_pend = 1'b1;
						pset = 1'b1;
					end
				end
				brk = 1'b0;
			end
		end
		st_next.stage = stg;
		if (i_count_load) begin
			for (int i = 0; i < NC; i++)
				st_next.ecnt[i] = i_chan[i].count;
		end
		// software clear loses to a match in the same cycle
		st_next.flags = st_next.flags & ~(i_flag_clr & ~fset);
		// post breaks fire once the matched instruction retires
		if (st_reg.post_pend && i_insn_done) begin
			st_next.brk_post = 1'b1;
			// a match in the retiring cycle stays pending for the next
			st_next.post_pend = pset;
		end
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg <= '0;
			st_reg.cnt <= btb_pkg::Q_CNT_RST;
			st_reg.flags <= btb_pkg::FLAGS_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign o_trace_source_reg      = st_reg.q[0].src;
	assign o_trace_destination_reg = st_reg.q[0].dst;
	assign o_trace_pointer_reg     = st_reg.q[0].ptr;
	assign o_trace_ptr_invalid     = st_reg.q[0].ptr_bad;
	assign o_trace_count           = st_reg.cnt;
	assign o_break_pre             = st_reg.brk_pre;
	assign o_break_post            = st_reg.brk_post;
	assign o_match_flags           = st_reg.flags;

	// checks
	// plain branch push with no queue read in the same cycle
	logic push_chk;
	assign push_chk = i_flow.valid && i_trace_enable_bit
		&& i_flow.kind == btb_pkg::BTB_FLOW_BRANCH
		&& !i_rd_trace_destination;

	property p_no_trace_off;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(!i_trace_enable_bit && !i_rd_trace_destination)
			|=> $stable(o_trace_count);
	endproperty
	a_no_trace_off: assert property (p_no_trace_off)
		else $error("trace captured while disabled");

	property p_push_dst;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(push_chk && st_reg.cnt == 3'h0)
			|=> o_trace_destination_reg == $past(i_flow.dst);
	endproperty
	a_push_dst: assert property (p_push_dst)
		else $error("destination not captured into empty queue");

	property p_short_loop;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_flow.valid && i_flow.kind == btb_pkg::BTB_FLOW_REPEAT
			&& i_flow.loop_len <= 3'h3 && !i_rd_trace_destination)
			|=> $stable(o_trace_count);
	endproperty
	a_short_loop: assert property (p_short_loop)
		else $error("short loop produced a trace entry");

	property p_q_bound;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_trace_count <= 3'h4;
	endproperty
	a_q_bound: assert property (p_q_bound)
		else $error("trace queue over four entries");

	property p_pop;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_rd_trace_destination && !i_flow.valid && o_trace_count > 0)
			|=> o_trace_count == $past(o_trace_count) - 3'h1;
	endproperty
	a_pop: assert property (p_pop)
		else $error("destination read did not advance queue");

	property p_full_keeps;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(push_chk && o_trace_count == 3'h4)
			|=> o_trace_count == 3'h4;
	endproperty
	a_full_keeps: assert property (p_full_keeps)
		else $error("full queue lost its depth");

	property p_post_after;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_break_post |-> $past(i_insn_done) && $past(st_reg.post_pend);
	endproperty
	a_post_after: assert property (p_post_after)
		else $error("post break without retirement");

	property p_chain_d;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_seq_mode == btb_pkg::BTB_SEQ_CD && st_reg.stage != 3'h3
			&& raw[3] && !raw[0] && !raw[1])
			|=> !o_break_pre && !st_reg.post_pend;
	endproperty
	a_chain_d: assert property (p_chain_d)
		else $error("chain broke on d before c");
endmodule

// [sim/btb_core_model.sv]
`timescale 1ns/10ps
// stand-in for the core pipeline and the dma master; every change is
// launched at a rising edge so the block samples it one edge later
module btb_core_model (
	// clock
	input  wire logic            i_core_clk,
	// events toward the block
	output btb_pkg::btb_flow_s   o_flow,
	output btb_pkg::btb_cycle_s  o_cpu_cycle,
	output btb_pkg::btb_cycle_s  o_dma_cycle,
	output logic                 o_insn_done,
	output logic                 o_rd_dst
);
	// idle lines at time zero
	initial begin
		o_flow = '0;
		o_cpu_cycle = '0;
		o_dma_cycle = '0;
		o_insn_done = 1'h0;
		o_rd_dst = 1'h0;
	end

	// one change of flow; addresses and pointer inverted once the pulse ends so a
	// stale value can never pass for a held one
	task automatic flow(input logic [1:0] k, input logic [2:0] len,
		input logic pend, input logic [31:0] s, d, t, input logic [7:0] p);
		@(posedge i_core_clk);
		o_flow <= '{1'h1, btb_pkg::btb_flow_e'(k), len, pend, s, d, t, p};
		@(posedge i_core_clk);
		o_flow <= '{1'h0, btb_pkg::btb_flow_e'(k), len, pend, ~s, ~d, ~t, ~p};
		repeat (2) @(negedge i_core_clk);
	endtask

	// one bus cycle; fetches are always reads, address inverted afterwards
	task automatic bus(input logic dma, f, w, input logic [1:0] sz,
		input logic [31:0] a, dt);
		btb_pkg::btb_cycle_s c;
		c = '{1'h1, dma, f, w, btb_pkg::btb_size_e'(sz),
			btb_pkg::BTB_XY_MAIN, a, dt};
		@(posedge i_core_clk);
		o_cpu_cycle <= dma ? o_cpu_cycle : c;
		o_dma_cycle <= dma ? c : o_dma_cycle;
		c.valid = 1'h0;
		c.addr = ~a;
		c.data = ~dt;
		@(posedge i_core_clk);
		o_cpu_cycle <= dma ? o_cpu_cycle : c;
		o_dma_cycle <= dma ? c : o_dma_cycle;
	endtask

	// one y-memory word write from the cpu; address inverted afterwards
	task automatic ybus(input logic [15:0] a, dt);
		btb_pkg::btb_cycle_s c;
		c = '{1'h1, 1'h0, 1'h0, 1'h1, btb_pkg::BTB_SZ_W, btb_pkg::BTB_XY_Y,
			{16'h0000, a}, {16'h0000, dt}};
		@(posedge i_core_clk);
		o_cpu_cycle <= c;
		c.valid = 1'h0;
		c.addr = ~c.addr;
		@(posedge i_core_clk);
		o_cpu_cycle <= c;
	endtask

	// one instruction retires
	task automatic retire;
		@(posedge i_core_clk);
		o_insn_done <= 1'h1;
		@(posedge i_core_clk);
		o_insn_done <= 1'h0;
	endtask

	// pointer and source are read as whole longwords off the head; only
	// the destination read is a strobe, and it comes last
	task automatic pop;
		@(posedge i_core_clk);
		o_rd_dst <= 1'h1;
		@(posedge i_core_clk);
		o_rd_dst <= 1'h0;
		repeat (2) @(negedge i_core_clk);
	endtask
endmodule

// [sim/tb_btb_top.sv]
`timescale 1ns/10ps
// self-checking bench: trace queue and break matching
module tb_btb_top;
	logic                 core_clk;              // 10 MHz core clock
	logic                 rst_b;                 // async reset, low
	logic                 trace_en;              // capture enable
	btb_pkg::btb_seq_e    seq_mode;              // chain mode
	btb_pkg::btb_chan_s   ch [btb_pkg::NUM_CH];  // channel conditions
	logic                 cnt_load;              // counter load pulse
	logic [3:0]           flag_clr;              // flag clear pulses
	btb_pkg::btb_flow_s   flow;                  // from the core model
	btb_pkg::btb_cycle_s  cpu_cyc;
	btb_pkg::btb_cycle_s  dma_cyc;
	logic                 insn_done;
	logic                 rd_dst;
	logic [31:0]          src;                   // head of the queue
	logic [31:0]          dst;
	logic [7:0]           ptr;
	logic                 ptr_bad;
	logic [2:0]           cnt;
	logic                 brk_pre;
	logic                 brk_post;
	logic [3:0]           flags;
	logic [3:0]           np;                    // pre pulses in window
	logic [3:0]           nq;                    // post pulses in window
	int                   fail_count;
	int                   total_checks;

	// half period of 50 ns
	always #50 core_clk = ~core_clk;

	btb_top btb_top_i (
		.i_core_clk(core_clk), .i_rst_b(rst_b),
		.i_trace_enable_bit(trace_en), .i_flow(flow),
		.i_rd_trace_destination(rd_dst), .o_trace_source_reg(src),
		.o_trace_destination_reg(dst), .o_trace_pointer_reg(ptr),
		.o_trace_ptr_invalid(ptr_bad), .o_trace_count(cnt),
		.i_seq_mode(seq_mode), .i_chan(ch), .i_count_load(cnt_load),
		.i_flag_clr(flag_clr), .i_cpu_cycle(cpu_cyc),
		.i_dma_cycle(dma_cyc), .i_insn_done(insn_done),
		.o_break_pre(brk_pre), .o_break_post(brk_post),
		.o_match_flags(flags));

	btb_core_model btb_core_model_i (
		.i_core_clk(core_clk), .o_flow(flow), .o_cpu_cycle(cpu_cyc),
		.o_dma_cycle(dma_cyc), .o_insn_done(insn_done), .o_rd_dst(rd_dst));

	// one compare; case inequality so unknowns never match
	task automatic chk(input string n, input logic [31:0] e, s);
		total_checks++;
		if (e !== s) begin
			$display("BAD %s exp %h got %h", n, e, s);
			fail_count++;
		end
	endtask

	// verdict, the only end of the run
	task automatic finish_test;
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// four-cycle reset; conditions dropped so no scenario leaks state
	task automatic do_reset;
		@(posedge core_clk);
		rst_b <= 1'h0;
		seq_mode <= btb_pkg::BTB_SEQ_NONE;
		foreach (ch[i]) ch[i] <= '0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'h1;
	endtask

	// cpu or dma condition, size and data left open
	function automatic btb_pkg::btb_chan_s cf(input logic [31:0] a, m,
		input logic f, input logic [1:0] dr, input logic pre, dm);
		cf = '0;
		cf.en_cpu = !dm;
		cf.en_dma = dm;
		cf.sel_fetch = f;
		cf.sel_data = !f;
		cf.dir = btb_pkg::btb_dir_e'(dr);
		cf.pre = pre;
		cf.addr = a;
		cf.amask = m;
	endfunction

	// count break pulses over six cycles while one instruction retires
	task automatic brk(input logic [3:0] ep, eq);
		np = '0;
		nq = '0;
		fork
			btb_core_model_i.retire();
			repeat (6) begin
				@(negedge core_clk);
				np = np + {3'h0, brk_pre};
				nq = nq + {3'h0, brk_post};
			end
		join
		chk("break_pre", {28'h0, ep}, {28'h0, np});
		chk("break_post", {28'h0, eq}, {28'h0, nq});
	endtask

	// gating, fields, short loops, overflow, pops down to empty
	task automatic t_trace;
		btb_core_model_i.flow(2'h0, 3'h7, 1'h0, 32'h100, 32'h200, 32'h0, 8'h2);
		chk("count", 32'h0, {29'h0, cnt});
		@(posedge core_clk);
		trace_en <= 1'h1;
		btb_core_model_i.flow(2'h0, 3'h7, 1'h0, 32'h100, 32'h200, 32'h0, 8'h2);
		chk("count", 32'h1, {29'h0, cnt});
		chk("source", 32'h100, src);
		chk("dest", 32'h200, dst);
		chk("pointer", 32'h2, {23'h0, ptr_bad, ptr});
		btb_core_model_i.flow(2'h1, 3'h3, 1'h0, 32'h150, 32'h250, 32'h0, 8'h1);
		chk("count", 32'h1, {29'h0, cnt});
		btb_core_model_i.flow(2'h1, 3'h4, 1'h0, 32'h300, 32'h400, 32'h0, 8'h1);
		btb_core_model_i.flow(2'h2, 3'h7, 1'h1, 32'h500, 32'h600, 32'hA02, 8'h3);
		btb_core_model_i.flow(2'h0, 3'h7, 1'h0, 32'h700, 32'h800, 32'h0, 8'h4);
		btb_core_model_i.flow(2'h0, 3'h7, 1'h0, 32'h900, 32'hA00, 32'h0, 8'h5);
		chk("count", 32'h4, {29'h0, cnt});
		chk("source", 32'h300, src);
		btb_core_model_i.pop();
		chk("source", 32'hA02, src);
		chk("ptr_bad", 32'h1, {31'h0, ptr_bad});
		chk("dest", 32'h600, dst);
		chk("count", 32'h3, {29'h0, cnt});
		repeat (4) btb_core_model_i.pop();
		chk("count", 32'h0, {29'h0, cnt});
	endtask

	// masked fetch range, pre break, sticky flag and its clear
	task automatic t_mask;
		do_reset();
		ch[1] <= cf(32'h3080, 32'h7F, 1'h1, 2'h0, 1'h1, 1'h0);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h30FE, 32'h0);
		brk(4'h1, 4'h0);
		chk("flags", 32'h2, {28'h0, flags});
		@(posedge core_clk);
		flag_clr <= 4'hF;
		@(posedge core_clk);
		flag_clr <= 4'h0;
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h3100, 32'h0);
		brk(4'h0, 4'h0);
		chk("flags", 32'h0, {28'h0, flags});
	endtask

	// post fetch waits for retirement; write fetch and dma fetch never hit
	task automatic t_fetch;
		do_reset();
		ch[0] <= cf(32'h404, 32'h0, 1'h1, 2'h0, 1'h0, 1'h0);
		ch[1] <= cf(32'h27128, 32'h0, 1'h1, 2'h2, 1'h1, 1'h0);
		ch[2] <= cf(32'h314156, 32'h0, 1'h1, 2'h1, 1'h1, 1'h1);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h404, 32'h0);
		brk(4'h0, 4'h1);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h27128, 32'h0);
		brk(4'h0, 4'h0);
		btb_core_model_i.bus(1'h1, 1'h1, 1'h0, 2'h3, 32'h314156, 32'h0);
		brk(4'h0, 4'h0);
	endtask

	// unsized read at every size; word write compared on data
	task automatic t_data;
		btb_pkg::btb_chan_s c;
		do_reset();
		c = cf(32'hABCDE, 32'hFF, 1'h0, 2'h2, 1'h0, 1'h0);
		c.size = btb_pkg::BTB_SZ_W;
		c.data_en = 1'h1;
		c.data = 32'hA512;
		ch[2] <= c;
		c = cf(32'h1001E000, 32'hFFFF0000, 1'h0, 2'h2, 1'h0, 1'h0);
		c.size = btb_pkg::BTB_SZ_W;
		c.xy_en = 1'h1;
		c.y_sel = 1'h1;
		c.data_en = 1'h1;
		c.data = 32'h4567;
		ch[3] <= c;
		ch[0] <= cf(32'h123456, 32'h0, 1'h0, 2'h1, 1'h0, 1'h0);
		for (int k = 1; k < 4; k++) begin
			btb_core_model_i.bus(1'h0, 1'h0, 1'h0, k[1:0], 32'h123456, 32'h0);
			brk(4'h0, 4'h1);
		end
		btb_core_model_i.bus(1'h0, 1'h0, 1'h1, 2'h2, 32'hABC00, 32'hA512);
		brk(4'h0, 4'h1);
		btb_core_model_i.bus(1'h0, 1'h0, 1'h1, 2'h2, 32'hABCFE, 32'hA513);
		brk(4'h0, 4'h0);
		btb_core_model_i.ybus(16'hE000, 16'h4567);
		brk(4'h0, 4'h1);
		btb_core_model_i.ybus(16'hE002, 16'h4567);
		brk(4'h0, 4'h0);
	endtask

	// c then d order; an unmatchable head blocks the chain
	task automatic t_seq;
		do_reset();
		seq_mode <= btb_pkg::BTB_SEQ_CD;
		ch[2] <= cf(32'h37226, 32'h0, 1'h1, 2'h1, 1'h1, 1'h0);
		ch[3] <= cf(32'h3722E, 32'h0, 1'h1, 2'h1, 1'h1, 1'h0);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h3722E, 32'h0);
		brk(4'h0, 4'h0);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h37226, 32'h0);
		brk(4'h0, 4'h0);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h3722E, 32'h0);
		brk(4'h1, 4'h0);
		do_reset();
		seq_mode <= btb_pkg::BTB_SEQ_CD;
		ch[2] <= cf(32'h37226, 32'h0, 1'h1, 2'h2, 1'h1, 1'h0);
		ch[3] <= cf(32'h3722E, 32'h0, 1'h1, 2'h1, 1'h1, 1'h0);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h37226, 32'h0);
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h3722E, 32'h0);
		brk(4'h0, 4'h0);
	endtask

	// counts of 5 on c and 10 on d: break before the tenth d fetch
	task automatic t_count;
		btb_pkg::btb_chan_s c;
		btb_pkg::btb_chan_s d;
		do_reset();
		c = cf(32'hA00, 32'h0, 1'h1, 2'h1, 1'h1, 1'h0);
		c.cnt_en = 1'h1;
		c.count = 16'h5;
		d = cf(32'h1000, 32'h0, 1'h1, 2'h1, 1'h1, 1'h0);
		d.cnt_en = 1'h1;
		d.count = 16'hA;
		seq_mode <= btb_pkg::BTB_SEQ_CD;
		ch[2] <= c;
		ch[3] <= d;
		@(posedge core_clk);
		cnt_load <= 1'h1;
		@(posedge core_clk);
		cnt_load <= 1'h0;
		repeat (5) btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'hA00, 32'h0);
		repeat (9) begin
			btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h1000, 32'h0);
			brk(4'h0, 4'h0);
		end
		btb_core_model_i.bus(1'h0, 1'h1, 1'h0, 2'h2, 32'h1000, 32'h0);
		brk(4'h1, 4'h0);
	endtask

	// main sequence
	initial begin
		core_clk = 1'h0;
		rst_b = 1'h0;
		trace_en = 1'h0;
		seq_mode = btb_pkg::BTB_SEQ_NONE;
		foreach (ch[i]) ch[i] = '0;
		cnt_load = 1'h0;
		flag_clr = 4'h0;
		fail_count = 0;
		total_checks = 0;
		do_reset();
		t_trace();
		t_mask();
		t_fetch();
		t_data();
		t_seq();
		t_count();
		finish_test();
	end
endmodule
